/* logic/spi_master.sv */
// Purpose: apb-attached spi master moving one byte per data port write
// Assumes: miso comes from off-chip and is synchronised; slave select is a gpio
// Notes: zero-wait apb slave; the transfer-done pulse feeds the system interrupt
//
// How it works
// [R1] data port write fills transmit buffer; read returns receive buffer
// [R2] only a buffered data port byte in master mode starts a byte transfer; a byte written in another mode waits and starts when master mode is set
// [R3] eight bits go out msb first with the driven serial clock
// [R4] miso bits replace outgoing byte; at end copy to receive, pulse request
// [R5] a newer completed byte overwrites an unread receive buffer
// [R6] firmware drives slave select from a gpio; no select made here
// [R7] idle shifter takes the buffered byte at once and starts shifting
// [R8] while busy, next byte loads in the same cycle the current byte reaches receive buffer
// [R9] buffer-full flag high from write until byte moves into shifter
// [R10] write while buffer full replaces the waiting byte
// [R11] drive mosi and sck out, sample miso in
// [R12] four shift rates chosen by the rate select field
// [R13] exactly eight sck pulses per byte
// [R14] sck phase and idle level follow phase and polarity selects
// [R15] sck active share one third at fastest rate, half otherwise
// [R16] firmware sets port bits to one and configures miso as input
// [R17] mode field: 00 off, 01 master, 10 slave, 11 reserved
// [R18] rate codes 00..11 give 2, 1, 0.5, 0.0625 Mbit/s
// [R19] transfer-complete flag set by hardware at byte end, cleared by firmware
// [R20] polarity one idles sck high, zero idles low
// [R21] phase zero samples on first edge; phase one samples on second
`timescale 1ns/1ps
`default_nettype none

module spi_master (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic miso, // serial data from slave
  output spi_pkg::spi_out_s spi_o, // sck, mosi and pin drive enable
  output logic xfer_done // one-cycle interrupt request per byte
);
  import spi_pkg::*;

  cfg_s cfg_r;
  eng_e st_r, st_nxt;
  logic [7:0] tx_r, rx_r, sh_r, sh_nxt;
  logic tbf_r, transfer_complete_flag_r, done_r, sck_r, mosi_r, mosi_nxt;
  logic [9:0] cnt_r, cnt_nxt, lead_len, trail_len;
  logic [2:0] bit_r, bit_nxt;
  logic miso_m_r, miso_s_r;
  logic [31:0] prdata_r;
  logic [3:0] pulse_cnt_r;

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_data = paddr == DATA_ADDR;
  wire hit_ctrl = paddr == CTRL_ADDR;
  wire wr_data = access & pwrite & hit_data;
  wire wr_ctrl = access & pwrite & hit_ctrl;
  wire rd_setup = setup & ~pwrite;
  wire [7:0] ctrl_rd = {transfer_complete_flag_r, tbf_r, cfg_r};
  wire is_master = cfg_r.mode == MODE_MASTER; // [R17]

  assign pready = 1'b1;
  assign pslverr = access & ~(hit_data | hit_ctrl);
  assign prdata = prdata_r;

  // engine control terms
  wire phase_end = cnt_r == 10'h000;
  wire last_bit = bit_r == LAST_BIT;
  wire finish = is_master & (st_r == ST_TRAIL) & phase_end & last_bit;
  // buffered byte leaves for the shifter: idle, or right after a byte ends
  wire take = is_master & tbf_r & ((st_r == ST_IDLE) | finish); // [R2] [R7] [R8]

  // phase lengths from rate select
  always_comb begin
    unique case (cfg_r.rate) // [R12] [R18]
      2'h0: begin
        lead_len = LEAD_R0; // [R15]
        trail_len = TRAIL_R0;
      end
      2'h1: begin
        lead_len = HALF_R1;
        trail_len = HALF_R1;
      end
      2'h2: begin
        lead_len = HALF_R2;
        trail_len = HALF_R2;
      end
      2'h3: begin
        lead_len = HALF_R3;
        trail_len = HALF_R3;
      end
    endcase
  end

  // shift engine next state
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    mosi_nxt = mosi_r;
    bit_nxt = bit_r;
    cnt_nxt = phase_end ? cnt_r : cnt_r - 10'h001;
    if (!is_master) begin
      // leaving master mode abandons any byte in flight
      st_nxt = ST_IDLE;
      cnt_nxt = 10'h000;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (take) begin
            st_nxt = ST_SETUP; // [R7]
            cnt_nxt = trail_len - 10'h001;
            sh_nxt = tx_r;
            bit_nxt = 3'h0;
            if (!cfg_r.clock_phase_select) mosi_nxt = tx_r[7]; // [R3]
          end
        end
        ST_SETUP, ST_TRAIL: begin
          if (phase_end && st_r == ST_TRAIL && last_bit) begin
            if (take) begin
              st_nxt = ST_SETUP; // [R8]
              cnt_nxt = trail_len - 10'h001;
              sh_nxt = tx_r;
              bit_nxt = 3'h0;
              if (!cfg_r.clock_phase_select) mosi_nxt = tx_r[7];
            end else begin
              st_nxt = ST_IDLE;
            end
          end else if (phase_end) begin
            // first edge of a bit
            st_nxt = ST_LEAD;
            cnt_nxt = lead_len - 10'h001;
            if (st_r == ST_TRAIL) bit_nxt = bit_r + 3'h1;
            if (!cfg_r.clock_phase_select) sh_nxt = {sh_r[6:0], miso_s_r}; // [R21] [R4]
            else mosi_nxt = sh_r[7]; // [R21] [R3]
          end
        end
        ST_LEAD: begin
          if (phase_end) begin
            // second edge of a bit
            st_nxt = ST_TRAIL;
            cnt_nxt = trail_len - 10'h001;
            if (!cfg_r.clock_phase_select) mosi_nxt = sh_r[7]; // [R21]
            else sh_nxt = {sh_r[6:0], miso_s_r}; // [R21] [R4]
          end
        end
      endcase
    end
  end

  // miso synchroniser: only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= miso; // [R11]
      miso_s_r <= miso_m_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 10'h000;
      bit_r <= 3'h0;
      sh_r <= DATA_RST;
      mosi_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      mosi_r <= mosi_nxt; // [R11]
      sck_r <= cfg_r.clock_polarity_select ^ (st_nxt == ST_LEAD); // [R13] [R14] [R20]
    end
  end

  // registers and flags; a hardware set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
      tx_r <= DATA_RST;
      rx_r <= DATA_RST;
      tbf_r <= 1'b0;
      transfer_complete_flag_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (wr_ctrl) cfg_r <= cfg_s'(pwdata[CFG_MSB:0]); // [R17]
      if (wr_data) tx_r <= pwdata[7:0]; // [R1] [R10]
      if (finish) rx_r <= sh_r; // [R4] [R5]
      tbf_r <= wr_data | (tbf_r & ~take); // [R9]
      transfer_complete_flag_r <= finish | (transfer_complete_flag_r & ~(wr_ctrl & ~pwdata[TRANSFER_COMPLETE_FLAG_BIT])); // [R19]
      done_r <= finish; // [R4]
    end
  end

  // read data captured in the setup phase so the answer is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= hit_data ? {24'h00_0000, rx_r} : // [R1]
                  hit_ctrl ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
    end
  end

  assign spi_o = '{sck: sck_r, mosi: mosi_r, out_en: is_master}; // [R11]
  assign xfer_done = done_r;

  // helper: sck pulses seen in the current byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_cnt_r <= 4'h0;
    else if (take) pulse_cnt_r <= 4'h0;
    else if (st_r != ST_LEAD && st_nxt == ST_LEAD) pulse_cnt_r <= pulse_cnt_r + 4'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_write;
    wr_data |=> tbf_r && tx_r == $past(pwdata[7:0]);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("data write lost"); // [R1]

  property p_read_rx;
    rd_setup && hit_data |=> prdata == {24'h00_0000, $past(rx_r)};
  endproperty
  a_read_rx: assert property (p_read_rx) else $error("rx read wrong"); // [R1]

  property p_start_cause;
    (st_r == ST_IDLE && st_nxt != ST_IDLE) |-> tbf_r && is_master;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("unrequested start"); // [R2]

  property p_eight_pulses;
    finish |-> pulse_cnt_r == 4'h8;
  endproperty
  a_eight_pulses: assert property (p_eight_pulses) else $error("pulse count not 8"); // [R13]

  property p_done_flags;
    finish |=> done_r && transfer_complete_flag_r && rx_r == $past(sh_r);
  endproperty
  a_done_flags: assert property (p_done_flags) else $error("completion not flagged"); // [R19]

  property p_tbf_clear;
    take && !wr_data |=> !tbf_r;
  endproperty
  a_tbf_clear: assert property (p_tbf_clear) else $error("tbf stuck"); // [R9]

  property p_chain;
    finish && tbf_r |=> st_r == ST_SETUP && sh_r == $past(tx_r);
  endproperty
  a_chain: assert property (p_chain) else $error("queued byte not loaded"); // [R8]

  property p_idle_level;
    st_r == ST_IDLE && $past(st_r) == ST_IDLE && $stable(cfg_r.clock_polarity_select) |-> sck_r == cfg_r.clock_polarity_select;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("sck idle level"); // [R20]

  property p_fast_lead;
    (st_r == ST_LEAD && $past(st_r) != ST_LEAD && cfg_r.rate == 2'h0 && is_master)
      |-> (st_r == ST_LEAD)[*6] ##1 (st_r != ST_LEAD);
  endproperty
  a_fast_lead: assert property (p_fast_lead) else $error("fast lead length"); // [R15]

  property p_sample_first;
    (st_r == ST_LEAD && $past(st_r) != ST_LEAD && !cfg_r.clock_phase_select) |-> sh_r[0] == $past(miso_s_r);
  endproperty
  a_sample_first: assert property (p_sample_first) else $error("phase 0 sample"); // [R21]

  property p_mosi_first;
    (st_r == ST_LEAD && $past(st_r) != ST_LEAD && cfg_r.clock_phase_select) |-> mosi_r == $past(sh_r[7]);
  endproperty
  a_mosi_first: assert property (p_mosi_first) else $error("phase 1 drive"); // [R3]

  // data must hold while the far side may sample it
  property p_mosi_hold;
    st_r == ST_LEAD && $past(st_r) == ST_LEAD |-> $stable(mosi_r);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved in lead"); // [R21]

  property p_transfer_complete_flag_hold;
    transfer_complete_flag_r && !(wr_ctrl && !pwdata[TRANSFER_COMPLETE_FLAG_BIT]) |=> transfer_complete_flag_r;
  endproperty
  a_transfer_complete_flag_hold: assert property (p_transfer_complete_flag_hold) else $error("transfer_complete_flag lost"); // [R19]

  property p_rx_hold;
    !finish |=> rx_r == $past(rx_r);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx changed mid byte"); // [R4]

  c_chain: cover property (finish && tbf_r);
  c_phase1: cover property (finish && cfg_r.clock_phase_select);
  c_slow: cover property (finish && cfg_r.rate == 2'h3);
  c_overwrite: cover property (wr_data && tbf_r);
  c_polarity: cover property (finish && cfg_r.clock_polarity_select);

endmodule : spi_master

`default_nettype wire

/* pkg/spi_pkg.sv */
// Purpose: shared constants and types for the byte-serial spi master block
// Assumes: 40 MHz pclk, 32-bit apb data, one register per aligned word
// Notes: register indices are multiplied by four to form byte addresses
`default_nettype none
package spi_pkg;

  // register indices and byte addresses
  localparam logic [7:0] DATA_IDX = 8'h60;
  localparam logic [7:0] CTRL_IDX = 8'h61;
  localparam logic [11:0] DATA_ADDR = {2'b00, DATA_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};

  // control register field positions
  localparam int TRANSFER_COMPLETE_FLAG_BIT = 7;
  localparam int TBF_BIT = 6;
  localparam int CFG_MSB = 5;

  // comm mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;

  // timing: bit periods per rate select code, in ns
  localparam int CLK_NS = 25;
  localparam int BIT_NS_R0 = 500;
  localparam int BIT_NS_R1 = 1000;
  localparam int BIT_NS_R2 = 2000;
  localparam int BIT_NS_R3 = 16000;
  localparam int BIT_CYC_R0 = BIT_NS_R0 / CLK_NS;
  localparam int BIT_CYC_R1 = BIT_NS_R1 / CLK_NS;
  localparam int BIT_CYC_R2 = BIT_NS_R2 / CLK_NS;
  localparam int BIT_CYC_R3 = BIT_NS_R3 / CLK_NS;
  // fastest rate: active clock phase is one third of the bit, else one half
  localparam logic [9:0] LEAD_R0 = 10'(BIT_CYC_R0 / 3);
  localparam logic [9:0] TRAIL_R0 = 10'(BIT_CYC_R0 - BIT_CYC_R0 / 3);
  localparam logic [9:0] HALF_R1 = 10'(BIT_CYC_R1 / 2);
  localparam logic [9:0] HALF_R2 = 10'(BIT_CYC_R2 / 2);
  localparam logic [9:0] HALF_R3 = 10'(BIT_CYC_R3 / 2);
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic [1:0] mode;
    logic clock_polarity_select;
    logic clock_phase_select;
    logic [1:0] rate;
  } cfg_s;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic out_en;
  } spi_out_s;

  localparam cfg_s CFG_RST = 6'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_LEAD = 4'b0100,
    ST_TRAIL = 4'b1000
  } eng_e;

endpackage : spi_pkg
`default_nettype wire

/* tb/spi_slave_model.sv */
// Purpose: behavioural spi slave on the far side of the master block
// Assumes: select is driven by the bench as firmware would drive a gpio
// Notes: received bits are shifted back out, so a second byte echoes the first
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input wire logic ss_n, // select, active low
  input wire logic sck, // serial clock from master
  input wire logic mosi, // data from master
  input wire logic clock_polarity_select, // idle level of sck
  input wire logic clock_phase_select, // phase setting
  input wire logic [7:0] tx_byte, // byte returned in the frame that select opens
  output logic miso, // data to master
  output logic [7:0] rx_byte // shift register, holds received byte
);
  logic ss_q;
  // one process owns both outputs so neither has a second driver
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    ss_q = 1'b1;
    forever begin
      @(ss_n or sck);
      if (ss_n !== ss_q) begin
        if (ss_n === 1'b0) begin
          rx_byte = tx_byte;
          if (!clock_phase_select) miso = tx_byte[7];
        end else begin
          // a released line shows the inverse so that a stale bit cannot pass
          miso = ~miso;
        end
        ss_q = ss_n;
      end else if (ss_n === 1'b0) begin
        if ((sck !== clock_polarity_select) ^ clock_phase_select) rx_byte = {rx_byte[6:0], mosi};
        else miso = rx_byte[7];
      end
    end
  end
endmodule : spi_slave_model
`default_nettype wire

/* tb/tb_spi_master_byte_transfer.sv */
// Purpose: self-checking bench for the spi master block
// Assumes: zero-wait apb; the bench plays firmware and drives the select
// Notes: every combination of rate, phase and polarity codes is swept once
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_byte_transfer;
  import spi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, miso, xfer_done, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  spi_out_s spi_o;
  logic ss_n, clock_polarity_select, clock_phase_select, done;
  logic [1:0] r;
  logic [7:0] s_tx, s_rx, m;
  int n_errors, cmp_count, tog, act, tf, tl;
  spi_master u_spi_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .miso(miso), .spi_o(spi_o), .xfer_done(xfer_done));
  spi_slave_model u_spi_slave_model (.ss_n(ss_n), .sck(spi_o.sck), .mosi(spi_o.mosi),
    .clock_polarity_select(clock_polarity_select), .clock_phase_select(clock_phase_select), .tx_byte(s_tx), .miso(miso), .rx_byte(s_rx));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("totals: mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic int bitc(input logic [1:0] c);
    return c == 2'h0 ? BIT_CYC_R0 : c == 2'h1 ? BIT_CYC_R1 : c == 2'h2 ? BIT_CYC_R2 : BIT_CYC_R3;
  endfunction : bitc
  function automatic int leadc(input logic [1:0] c);
    return c == 2'h0 ? BIT_CYC_R0 / 3 : bitc(c) / 2;
  endfunction : leadc
  // counts sck edges and active cycles until the done pulse or the limit
  task automatic wait_byte(input int lim);
    int n;
    logic p;
    p = spi_o.sck;
    tog = 0;
    act = 0;
    done = 1'b0;
    for (n = 1; n <= lim && !done; n++) begin
      @(posedge pclk);
      #1;
      if (spi_o.sck !== p) begin
        tog++;
        if (tog == 1) tf = n;
        tl = n;
        p = spi_o.sck;
      end
      if (spi_o.sck !== clock_polarity_select) act++;
      done = xfer_done === 1'b1;
    end
  endtask : wait_byte
  initial begin
    #2_000_000;
    n_errors++;
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {ss_n, clock_polarity_select, clock_phase_select, s_tx} = {3'h4, 8'h00};
    void'($urandom(32'h9E8C));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, DATA_ADDR, 0);
    chk("data reset", 0, rd);
    apb(0, CTRL_ADDR, 0);
    chk("ctrl reset", 0, rd);
    chk("out_en reset", 0, spi_o.out_en);
    apb(1, 12'h188, 32'hFF);
    chk("slverr", 1, err);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      {clock_polarity_select, clock_phase_select, r} = 4'(i);
      apb(1, CTRL_ADDR, {26'h0, MODE_MASTER, clock_polarity_select, clock_phase_select, r});
      apb(0, CTRL_ADDR, 0);
      chk("ctrl", {26'h0, MODE_MASTER, clock_polarity_select, clock_phase_select, r}, rd);
      chk("idle sck", clock_polarity_select, spi_o.sck);
      chk("out_en", 1, spi_o.out_en);
      m = 8'($urandom);
      s_tx = 8'($urandom);
      ss_n <= 1'b0;
      apb(1, DATA_ADDR, {24'h0, m});
      wait_byte(6000);
      chk("done", 1, done);
      chk("sck edges", 16, tog);
      chk("active cycles", 8 * leadc(r), act);
      chk("span", 7 * bitc(r) + leadc(r), tl - tf);
      @(posedge pclk);
      #1;
      chk("done pulse", 0, xfer_done);
      chk("slave rx", m, s_rx);
      apb(0, DATA_ADDR, 0);
      ss_n <= 1'b1;
      chk("master rx", s_tx, rd);
      apb(0, CTRL_ADDR, 0);
      chk("transfer_complete_flag", 1, rd[TRANSFER_COMPLETE_FLAG_BIT]);
    end
    $display("test sweep done");
    {clock_polarity_select, clock_phase_select, r} = 4'h0;
    apb(1, CTRL_ADDR, {26'h0, MODE_MASTER, 4'h0});
    s_tx = 8'($urandom);
    m = 8'($urandom);
    ss_n <= 1'b0;
    apb(1, DATA_ADDR, {24'h0, m});
    apb(1, DATA_ADDR, {24'h0, ~m});
    apb(0, CTRL_ADDR, 0);
    chk("tbf held", 1, rd[TBF_BIT]);
    apb(1, DATA_ADDR, {24'h0, m ^ 8'h5A});
    wait_byte(2000);
    chk("first byte", m, s_rx);
    apb(0, CTRL_ADDR, 0);
    chk("tbf clear", 0, rd[TBF_BIT]);
    wait_byte(2000);
    chk("second byte", m ^ 8'h5A, s_rx);
    apb(0, DATA_ADDR, 0);
    ss_n <= 1'b1;
    chk("overwritten rx", m, rd);
    $display("test back to back done");
    for (int k = 0; k < 3; k++) begin
      // off, slave and the reserved code must all leave the link quiet
      apb(1, CTRL_ADDR, {26'h0, k == 0 ? MODE_OFF : k == 1 ? MODE_SLAVE : 2'h3, 4'h0});
      apb(1, DATA_ADDR, {24'h0, 8'($urandom)});
      wait_byte(300);
      chk("no start", 0, done);
      chk("no sck", 0, tog);
      chk("out_en idle", 0, spi_o.out_en);
      apb(0, CTRL_ADDR, 0);
      chk("tbf parked", 1, rd[TBF_BIT]);
    end
    $display("test modes done");
    complete_run();
  end
endmodule : tb_spi_master_byte_transfer
`default_nettype wire
